// ==== src/ris_cfg.svh ====
// constants of the reset and initialization sequencer
`ifndef RIS_CFG_SVH
`define RIS_CFG_SVH
`define RIS_BR_BASE   32'hFFFF_FF00
`define RIS_SUM_SEED  32'hFFFF_FFFF
`define RIS_SUM_FIRST 32'h0000_0004
`define RIS_SUM_LAST  3'h7
`define RIS_IP_REL    3'h0
`define RIS_PCB_REL   3'h1
`define RIS_PCB_LAST  3'h3
`define RIS_SKIP_TIME_NS 400
`define RIS_SKIP_CYC  4'((`RIS_SKIP_TIME_NS + 99) / 100)
`endif

// ==== src/ris_pkg.sv ====
// types of the reset and initialization sequencer
package ris_pkg;
  typedef enum logic [2:0] {
    S_RESET = 3'h0,
    S_ITEST = 3'h1,
    S_GAP   = 3'h2,
    S_BTEST = 3'h3,
    S_PCB   = 3'h4,
    S_START = 3'h5,
    S_RUN   = 3'h6,
    S_HALT  = 3'h7
  } ris_state_t;
  typedef struct packed {
    logic [31:0]      ip;
    logic [31:0]      pcb;
    logic [31:0]      cfg;
    logic [2:0][31:0] ptr;
  } ris_imi_t;
endpackage : ris_pkg

// ==== src/ris_top.sv ====
// reset and initialization sequencer with self tests and board-test float
`timescale 1ns/1ps
`include "ris_cfg.svh"
module ris_top import ris_pkg::*; (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        SELF_TEST_REQUEST_IN,
  input  wire logic        BOARD_TEST_N_IN,
  input  wire logic        ITEST_DONE_IN,
  input  wire logic        ITEST_PASS_IN,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [31:0] MEM_DATA_IN,
  input  wire logic        REINIT_REQ_IN,
  input  wire logic [31:0] REINIT_PCB_IN,
  input  wire logic [31:0] REINIT_IP_IN,
  output logic             ITEST_START_OUT,
  output logic             MEM_RD_OUT,
  output logic [31:0]      MEM_ADDR_OUT,
  output logic             FAIL_N_OUT,
  output logic             HALT_OUT,
  output logic             PIN_OE_OUT,
  output logic             START_OUT,
  output logic             RUNNING_OUT,
  output ris_imi_t         IMAGE_OUT
);

  // ********************************
  // reset and strap synchronisers
  // ********************************
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [1:0]  self_test_request_sync;
  logic [1:0]  once_sync;
  ris_state_t  state;
  logic [2:0]  idx;
  logic [3:0]  cnt;
  logic [31:0] sum;
  logic [31:0] next_sum;
  logic        self_test_request_lat;
  logic        once_lat_n;

  // the external pin is the only reset source; no internal path asserts it
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // straps carry no reset so they keep sampling while reset is held
  always_ff @(posedge CLK_IN) begin
    self_test_request_sync <= {self_test_request_sync[0], SELF_TEST_REQUEST_IN};
    once_sync  <= {once_sync[0], BOARD_TEST_N_IN};
  end

  assign next_sum = sum + MEM_DATA_IN;

  // ********************************
  // strap latch
  // ********************************
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      self_test_request_lat  <= 1'b0;
      once_lat_n <= 1'b1;
    end else if (state == S_RESET) begin
      self_test_request_lat  <= self_test_request_sync[1];
      once_lat_n <= once_sync[1];
    end
  end

  // ********************************
  // initialization sequencer
  // ********************************
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state           <= S_RESET;
      idx             <= 3'h0;
      cnt             <= 4'h0;
      sum             <= `RIS_SUM_SEED;
      ITEST_START_OUT <= 1'b0;
      MEM_RD_OUT      <= 1'b0;
      MEM_ADDR_OUT    <= 32'h0000_0000;
      FAIL_N_OUT      <= 1'b0;
      HALT_OUT        <= 1'b0;
      PIN_OE_OUT      <= 1'b0;
      START_OUT       <= 1'b0;
      RUNNING_OUT     <= 1'b0;
      IMAGE_OUT       <= '0;
    end else begin
      ITEST_START_OUT <= 1'b0;
      START_OUT       <= 1'b0;
      case (state)
        S_RESET: begin
          if (once_sync[1]) begin
            PIN_OE_OUT      <= 1'b1;
            cnt             <= 4'h0;
            ITEST_START_OUT <= self_test_request_sync[1];
            state           <= S_ITEST;
          end else begin
            state <= S_HALT;
          end
        end
        S_ITEST: begin
          if (!self_test_request_lat) begin
            // skipped test still pulses the failure pin so boards see the same shape
            cnt <= cnt + 4'h1;
            if (cnt == `RIS_SKIP_CYC - 4'h1) begin
              FAIL_N_OUT <= 1'b1;
              state      <= S_GAP;
            end
          end else if (ITEST_DONE_IN) begin
            if (ITEST_PASS_IN) begin
              FAIL_N_OUT <= 1'b1;
              state      <= S_GAP;
            end else begin
              HALT_OUT <= 1'b1;
              state    <= S_HALT;
            end
          end
        end
        S_GAP: begin
          FAIL_N_OUT <= 1'b0;
          idx        <= 3'h0;
          sum        <= `RIS_SUM_SEED;
          state      <= S_BTEST;
        end
        S_BTEST: begin
          if (MEM_RD_OUT && MEM_ACK_IN) begin
            MEM_RD_OUT <= 1'b0;
            sum        <= next_sum;
            idx        <= idx + 3'h1;
            if (idx == `RIS_IP_REL) begin
              IMAGE_OUT.ip <= MEM_DATA_IN;
            end
            if (idx == `RIS_PCB_REL) begin
              IMAGE_OUT.pcb <= MEM_DATA_IN;
            end
            if (idx == `RIS_SUM_LAST) begin
              idx <= 3'h0;
              if (next_sum == 32'h0000_0000) begin
                FAIL_N_OUT <= 1'b1;
                state      <= S_PCB;
              end else begin
                HALT_OUT <= 1'b1;
                state    <= S_HALT;
              end
            end
          end else if (!MEM_RD_OUT) begin
            MEM_RD_OUT   <= 1'b1;
            MEM_ADDR_OUT <= `RIS_BR_BASE + ((32'(idx) + `RIS_SUM_FIRST) << 2);
          end
        end
        S_PCB: begin
          if (MEM_RD_OUT && MEM_ACK_IN) begin
            MEM_RD_OUT <= 1'b0;
            idx        <= idx + 3'h1;
            if (idx == 3'h0) begin
              IMAGE_OUT.cfg <= MEM_DATA_IN;
            end else begin
              IMAGE_OUT.ptr[2'(idx - 3'h1)] <= MEM_DATA_IN;
            end
            if (idx == `RIS_PCB_LAST) begin
              state <= S_START;
            end
          end else if (!MEM_RD_OUT) begin
            MEM_RD_OUT   <= 1'b1;
            MEM_ADDR_OUT <= IMAGE_OUT.pcb + (32'(idx) << 2);
          end
        end
        S_START: begin
          START_OUT   <= 1'b1;
          RUNNING_OUT <= 1'b1;
          state       <= S_RUN;
        end
        S_RUN: begin
          // reinit reuses the control block walk but skips both self tests
          if (REINIT_REQ_IN) begin
            IMAGE_OUT.ip  <= REINIT_IP_IN;
            IMAGE_OUT.pcb <= REINIT_PCB_IN;
            RUNNING_OUT   <= 1'b0;
            idx           <= 3'h0;
            state         <= S_PCB;
          end
        end
        S_HALT: begin
          state <= S_HALT;
        end
        default: begin
          state <= S_HALT;
        end
      endcase
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  chk_reset_entry: assert property (disable iff (1'b0) !RST_N_IN |-> !rst_n)
    else $error("internal reset not asserted with pin");
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !MEM_RD_OUT && !PIN_OE_OUT && !START_OUT
                                    && !FAIL_N_OUT && state == S_RESET)
    else $error("outputs not at reset levels");
  chk_release_sync: assert property (disable iff (1'b0) $rose(rst_n) |-> $past(RST_N_IN, 2))
    else $error("reset released without two clean edges");
  chk_no_early_read: assert property (state == S_RESET |-> !MEM_RD_OUT && !RUNNING_OUT)
    else $error("activity before initialization");
  chk_fail_in_test: assert property (state inside {S_ITEST, S_BTEST} |-> !FAIL_N_OUT)
    else $error("failure pin released during test");
  chk_fail_held: assert property (HALT_OUT |-> !FAIL_N_OUT ##1 (HALT_OUT && !FAIL_N_OUT))
    else $error("failure pin released after failed test");
  chk_sum_pass: assert property (state == S_BTEST && MEM_RD_OUT && MEM_ACK_IN && idx == 3'h7
                                 && next_sum == 32'h0 |=> state == S_PCB && FAIL_N_OUT)
    else $error("good checksum not accepted");
  chk_sum_fail: assert property (state == S_BTEST && MEM_RD_OUT && MEM_ACK_IN && idx == 3'h7
                                 && next_sum != 32'h0 |=> HALT_OUT)
    else $error("bad checksum not halted");
  chk_skip_itest: assert property (state == S_ITEST && !self_test_request_lat |-> !ITEST_START_OUT)
    else $error("internal test started while skipped");
  chk_float_pins: assert property (!once_lat_n |-> !PIN_OE_OUT && !MEM_RD_OUT)
    else $error("pins driven in board-test mode");
  chk_start_once: assert property (START_OUT |-> RUNNING_OUT ##1 !START_OUT)
    else $error("start pulse malformed");
  chk_reinit_load: assert property (state == S_RUN && REINIT_REQ_IN |=> state == S_PCB
                                    && IMAGE_OUT.ip == $past(REINIT_IP_IN) && FAIL_N_OUT)
    else $error("reinit did not load new pointers");

  cov_start: cover property (START_OUT && self_test_request_lat);
  cov_halt: cover property ($rose(HALT_OUT));
  cov_reinit: cover property (state == S_RUN && REINIT_REQ_IN);
  cov_board_test: cover property (!once_lat_n && state == S_HALT);

endmodule : ris_top

// ==== testbench/ris_mem_model.sv ====
// boot memory and internal test engine beside the sequencer
`timescale 1ns/1ps
module ris_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [3:0]  wait_in,
  input  wire logic        bad_in,
  input  wire logic        go_in,
  input  wire logic        ok_in,
  output logic             ack_out = 1'b0,
  output logic [31:0]      data_out = 32'h0,
  output logic             done_out = 1'b0,
  output logic             pass_out = 1'b0
);
  // ****************
  // memory contents
  // ****************
  int cnt = 0;
  int tcnt = 0;
  function automatic logic [31:0] word(input logic [31:0] a);
    case (a)
      32'hFFFF_FF10: word = 32'h0000_1000;
      32'hFFFF_FF14: word = 32'h0000_2000;
      // bad flips one bit so the sum misses zero
      32'hFFFF_FF2C: word = 32'hFFFF_D001 ^ {31'h0, bad_in};
      default: word = (a[31:8] == 24'hFFFFFF) ? 32'h0 : {8'h5A, a[23:0]};
    endcase
  endfunction : word
  always @(posedge clk_in) begin
    if (ack_out || !rd_in) begin
      ack_out  <= 1'b0;
      data_out <= ~data_out; // released bus never keeps the old word
      cnt      <= 0;
    end else if (cnt >= int'(wait_in)) begin
      ack_out  <= 1'b1;
      data_out <= word(addr_in);
    end else begin
      cnt <= cnt + 1;
    end
  end
  always @(posedge clk_in) begin
    tcnt     <= go_in ? 3 : (tcnt > 0 ? tcnt - 1 : 0);
    done_out <= (tcnt == 1);
    pass_out <= (tcnt == 1) ? ok_in : ~pass_out;
  end
endmodule : ris_mem_model

// ==== testbench/tb_ris_top.sv ====
// self-checking bench of the reset and initialization sequencer
`timescale 1ns/1ps
module tb_ris_top;
  import ris_pkg::*;
  localparam logic [31:0] PCB = 32'h0000_2000;
  localparam logic [31:0] NPCB = 32'h0000_3000;
  localparam logic [31:0] NIP = 32'h0000_4000;
  logic clk = 0, self_test_request = 1, brd_n = 1, reinit = 0, bad = 0, ok = 1, pf = 0;
  logic rst_n;
  logic [3:0] wt = 4'h0;
  logic done, pass, ack, go, rd, fail_n, halt, oe, start, run;
  logic [31:0] data, addr;
  ris_imi_t img;
  int miscompares = 0, n_checks = 0, n_rd = 0, n_go = 0, n_rise = 0;
  bit seen;
  always #50 clk = ~clk;
  ris_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SELF_TEST_REQUEST_IN(self_test_request), .BOARD_TEST_N_IN(brd_n),
    .ITEST_DONE_IN(done), .ITEST_PASS_IN(pass), .MEM_ACK_IN(ack), .MEM_DATA_IN(data),
    .REINIT_REQ_IN(reinit), .REINIT_PCB_IN(NPCB), .REINIT_IP_IN(NIP), .ITEST_START_OUT(go),
    .MEM_RD_OUT(rd), .MEM_ADDR_OUT(addr), .FAIL_N_OUT(fail_n), .HALT_OUT(halt), .PIN_OE_OUT(oe),
    .START_OUT(start), .RUNNING_OUT(run), .IMAGE_OUT(img));
  ris_mem_model mem (.clk_in(clk), .rd_in(rd), .addr_in(addr), .wait_in(wt), .bad_in(bad),
    .go_in(go), .ok_in(ok), .ack_out(ack), .data_out(data), .done_out(done), .pass_out(pass));
  always @(posedge clk) begin
    pf     <= fail_n;
    n_rd   <= rst_n ? n_rd + int'(rd === 1'b1 && ack) : 0;
    n_go   <= rst_n ? n_go + int'(go === 1'b1) : 0;
    n_rise <= rst_n ? n_rise + int'(fail_n === 1'b1 && !pf) : 0;
  end
  task automatic chk(input bit c, input string m);
    n_checks++;
    if (!c) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // ****************
  // scenarios
  // ****************
  task automatic do_reset(input logic st, input logic bd);
    @(negedge clk);
    rst_n = 0;
    self_test_request = st;
    brd_n = bd;
    #10 chk(fail_n === 0 && oe === 0 && run === 0 && rd === 0, "async entry");
    repeat (20) @(negedge clk);
    chk(start === 0 && halt === 0 && img === '0, "quiet in reset");
    rst_n = 1;
  endtask : do_reset
  task automatic wait_start;
    seen = 0;
    for (int i = 0; i < 400 && !seen; i++) begin
      @(negedge clk);
      seen = (start === 1'b1);
    end
  endtask : wait_start
  task automatic t_boot(input logic st, input logic [3:0] w);
    wt = w;
    do_reset(st, 1);
    wait_start;
    chk(seen && run === 1, "no start");
    chk(img.ip === 32'h0000_1000 && img.pcb === PCB, "boot pointers");
    chk(img.cfg === {8'h5A, PCB[23:0]} && img.ptr[2] === {8'h5A, PCB[23:0] + 24'hC}, "pcb words");
    chk(img.ptr[0] === {8'h5A, PCB[23:0] + 24'h4} && img.ptr[1] === {8'h5A, PCB[23:0] + 24'h8}, "low ptrs");
    chk(oe === 1 && halt === 0, "pins not driven");
    chk(n_rd == 12 && n_go == int'(st), "read or test count");
    chk(n_rise == 2 && fail_n === 1, "fail pin toggles");
  endtask : t_boot
  task automatic t_reinit;
    int r;
    r = n_rd;
    @(negedge clk) reinit = 1;
    @(negedge clk) reinit = 0;
    @(negedge clk) chk(run === 0, "still running");
    wait_start;
    chk(seen && img.ip === NIP && img.pcb === NPCB && img.cfg === {8'h5A, NPCB[23:0]}, "reinit");
    chk(fail_n === 1 && n_go == 1 && n_rd == r + 4, "reinit side");
  endtask : t_reinit
  task automatic t_fail(input logic itest);
    ok = !itest;
    bad = !itest;
    do_reset(1, 1);
    repeat (200) @(negedge clk);
    chk(halt === 1 && fail_n === 0 && run === 0, "no halt");
    chk(n_rd == (itest ? 0 : 8), "reads after fail");
    ok = 1;
    bad = 0;
  endtask : t_fail
  task automatic t_board;
    do_reset(1, 0);
    repeat (100) @(negedge clk);
    chk(oe === 0 && n_rd == 0 && n_go == 0 && run === 0 && halt === 0, "board float");
  endtask : t_board
  initial begin
    // nonblocking so the async reset sees a falling edge at power-up
    rst_n <= 1'b0;
    t_boot(1, 4'h0);
    t_reinit;
    t_boot(0, 4'h3);
    t_fail(1);
    t_fail(0);
    t_board;
    t_boot(1, 4'h1);
    conclude;
  end
  initial begin
    #(100 * 10000);
    miscompares++;
    conclude;
  end
endmodule : tb_ris_top
